// ### logic/ebu_consts.vh
`ifndef EBU_CONSTS_VH
`define EBU_CONSTS_VH
// ----------------------------------------------------------------
// bus configuration word layout
// ----------------------------------------------------------------
`define CFG_W 13
`define CFG_MUX 0
`define CFG_WIDE 1
`define CFG_WAIT_LSB 2
`define CFG_WAIT_MSB 5
`define CFG_TRI 6
`define CFG_ALEX 7
`define CFG_RWDLY 8
`define CFG_RDYEN 9
`define CFG_RDY_LVL 10
`define CFG_CSEN 11
`define CFG_ACTIVE 12
// ----------------------------------------------------------------
// window select word layout: base address bits 23..12, size code
// ----------------------------------------------------------------
`define SEL_BASE_MSB 15
`define SEL_BASE_LSB 4
`define SEL_SIZE_MSB 3
// ----------------------------------------------------------------
// address space restriction codes and segment masks
// ----------------------------------------------------------------
`define SPACE_16M 2'h0
`define SPACE_1M 2'h1
`define SPACE_256K 2'h2
`define SPACE_64K 2'h3
`define SEG_MASK_16M 8'hFF
`define SEG_MASK_1M 8'h0F
`define SEG_MASK_256K 8'h03
`define SEG_MASK_64K 8'h00
// ----------------------------------------------------------------
// window indices and sync reset values
// ----------------------------------------------------------------
`define WIN_DEFAULT 3'h0
`define WIN_ONE 3'h1
`define WIN_TWO 3'h2
`define WIN_THREE 3'h3
`define WIN_FOUR 3'h4
`define SYNC_RESET 3'h5
`define CS_IDLE 5'h1F
`endif

// ### logic/window_decoder.v
`include "ebu_consts.vh"
// priority decoder: which address window claims an address
module window_decoder (
  input wire [23:0] addr, // address under test
  input wire [15:0] sel1, // window 1 select word
  input wire [15:0] sel2, // window 2 select word
  input wire [15:0] sel3, // window 3 select word
  input wire [15:0] sel4, // window 4 select word
  input wire [3:0] act, // window active bits, bit 0 = window 1
  output reg [2:0] win // claiming window, 0 = default region
);
  // ----------------------------------------------------------------
  // match helper
  // ----------------------------------------------------------------
  // window spans 4 Kbyte shifted left by the size code
  function hit;
    input [23:0] a;
    input [15:0] s;
    reg [11:0] diff;
    begin
      diff = a[23:12] ^ s[`SEL_BASE_MSB:`SEL_BASE_LSB];
      hit = ((diff >> s[`SEL_SIZE_MSB:0]) == 12'h000);
    end
  endfunction

  // ----------------------------------------------------------------
  // priority: 4 over 3, 2 over 1; upper pair wins over lower pair
  // ----------------------------------------------------------------
  always @* begin
    win = `WIN_DEFAULT;
    if (act[3] && hit(addr, sel4)) begin
      win = `WIN_FOUR;
    end else if (act[2] && hit(addr, sel3)) begin
      win = `WIN_THREE;
    end else if (act[1] && hit(addr, sel2)) begin
      win = `WIN_TWO;
    end else if (act[0] && hit(addr, sel1)) begin
      win = `WIN_ONE;
    end
  end
endmodule // window_decoder

// ### logic/external_bus_unit.v
// Overview of operation
// - single-chip mode plus four external bus modes
// - 16/18/20/24-bit address, 8/16-bit data
// - demux: address port, full or low data
// - mux: one port carries address then data
// - programmable cycle, tri-state, ALE, rw delay
// - four windows, each select plus config
// - window 4 beats 3, 2 beats 1
// - unmatched addresses use default configuration
// - five active-low chip selects, window plus default
// - per-configuration ready polarity bit
// - arbitration enable hands pins to controller
// - reset gives master, release-ack pin undriven until arbitration on
// - port6 dir bit7 selects slave, ack input
// - space restriction drives 8/4/2/0 segment lines
// - default chip select half cycle after ALE
// - timing bit moves chip select onto ALE
`include "ebu_consts.vh"
module external_bus_unit (
  input wire MCLK, // system clock
  input wire SRST, // synchronous reset, high
  input wire REQ, // core access request pulse
  input wire REQ_WR, // 1 = write
  input wire [23:0] REQ_ADDR, // access address
  input wire [15:0] REQ_WDATA, // write data
  output reg ACK, // access done pulse
  output reg [15:0] RDATA, // read data
  output reg BUSY, // request in progress
  input wire SINGLE_CHIP, // no external accesses
  input wire [1:0] ADDR_SPACE, // address space restriction
  input wire CHIP_SELECT_TIMING_BIT, // chip select on ALE edge
  input wire ARBITRATION_ENABLE_BIT, // status word hold enable
  input wire PORT6_DIR_BIT7, // 1 = slave arbitration
  input wire [12:0] DEFAULT_BUS_CONFIG_REG, // default config
  input wire [12:0] WINDOW1_BUS_CONFIG, // window 1 config
  input wire [12:0] WINDOW2_BUS_CONFIG, // window 2 config
  input wire [12:0] WINDOW3_BUS_CONFIG, // window 3 config
  input wire [12:0] WINDOW4_BUS_CONFIG, // window 4 config
  input wire [15:0] WINDOW_SELECT_REG1, // window 1 select
  input wire [15:0] WINDOW_SELECT_REG2, // window 2 select
  input wire [15:0] WINDOW_SELECT_REG3, // window 3 select
  input wire [15:0] WINDOW_SELECT_REG4, // window 4 select
  output reg [15:0] ADDRESS_PORT, // demux address lines
  output reg [7:0] SEGMENT_PORT, // upper address lines
  output reg [15:0] DATA_MUX_PORT_O, // data/address out
  output reg [1:0] DATA_MUX_PORT_OE, // byte lane enables
  input wire [15:0] DATA_MUX_PORT_I, // data in
  output reg ALE, // address latch strobe
  output reg RD_N, // read strobe
  output reg WR_N, // write strobe
  output reg [4:0] CHIP_SELECT_N, // bit 0 default, k window k
  output reg BUS_OE, // address/control drive enable
  input wire READY_I, // ready pin
  input wire HOLD_N_I, // hold request pin
  output reg BUS_WANT_REQUEST_N, // bus request pin
  input wire BUS_RELEASE_ACK_N_I, // ack pin in (slave)
  output reg BUS_RELEASE_ACK_N_O, // ack pin out (master)
  output reg BUS_RELEASE_ACK_N_OE // ack pin drive enable
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam S_IDLE = 3'h0; // bus owned, nothing to do
  localparam S_ADDR = 3'h1; // ALE high
  localparam S_ALEX = 3'h2; // lengthened ALE
  localparam S_DLY = 3'h3; // read/write delay
  localparam S_STRB = 3'h4; // strobe, waits and ready
  localparam S_TRI = 3'h5; // tri-state recovery
  localparam S_HOLD = 3'h6; // bus given away
  localparam S_GNT = 3'h7; // slave waiting for grant

  reg [2:0] state_ff; // current state
  reg pend_ff; // accepted request not yet started
  reg wr_ff; // latched direction
  reg [23:0] addr_ff; // latched address
  reg [15:0] wdata_ff; // latched write data
  reg [2:0] win_ff; // latched window index
  reg [12:0] cfg_ff; // latched configuration
  reg [3:0] wcnt_ff; // wait state counter
  reg arb_on_ff; // arbitration taken over, sticky
  reg [2:0] sync1_ff; // {ack_n, ready, hold_n} stage 1
  reg [2:0] sync2_ff; // stage 2
  reg [2:0] sync3_ff; // stage 3
  reg [2:0] filt_ff; // accepted pin levels
  wire [2:0] win_sel; // decoder result for REQ_ADDR
  wire hold_req; // hold requested (pin low)
  wire ready_lvl; // filtered ready level
  wire granted; // slave: other master acknowledged
  wire slave; // slave arbitration mode
  wire go_start; // begin an external access now
  wire [2:0] flip; // stage 2 and 3 disagree
  reg [12:0] cfg_sel; // config of decoded window

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // segment lines driven for each space restriction
  function [7:0] seg_mask;
    input [1:0] sp;
    begin
      case (sp)
        `SPACE_16M: seg_mask = `SEG_MASK_16M;
        `SPACE_1M: seg_mask = `SEG_MASK_1M;
        `SPACE_256K: seg_mask = `SEG_MASK_256K;
        default: seg_mask = `SEG_MASK_64K;
      endcase
    end
  endfunction

  // active-low one-hot chip select, none if disabled
  function [4:0] cs_vec;
    input [2:0] w;
    input en;
    begin
      cs_vec = `CS_IDLE;
      if (en) begin
        cs_vec[w] = 1'b0;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // window decode
  // ----------------------------------------------------------------
  window_decoder u_dec (
    .addr(REQ_ADDR),
    .sel1(WINDOW_SELECT_REG1),
    .sel2(WINDOW_SELECT_REG2),
    .sel3(WINDOW_SELECT_REG3),
    .sel4(WINDOW_SELECT_REG4),
    .act({WINDOW4_BUS_CONFIG[`CFG_ACTIVE], WINDOW3_BUS_CONFIG[`CFG_ACTIVE],
          WINDOW2_BUS_CONFIG[`CFG_ACTIVE], WINDOW1_BUS_CONFIG[`CFG_ACTIVE]}),
    .win(win_sel)
  );

  // pick the config word belonging to the window
  always @* begin
    case (win_sel)
      `WIN_ONE: cfg_sel = WINDOW1_BUS_CONFIG;
      `WIN_TWO: cfg_sel = WINDOW2_BUS_CONFIG;
      `WIN_THREE: cfg_sel = WINDOW3_BUS_CONFIG;
      `WIN_FOUR: cfg_sel = WINDOW4_BUS_CONFIG;
      default: cfg_sel = DEFAULT_BUS_CONFIG_REG;
    endcase
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // three stages; a level counts once stages 2 and 3 agree
  assign flip = sync2_ff ^ sync3_ff;
  always @(posedge MCLK) begin
    if (SRST) begin
      sync1_ff <= `SYNC_RESET;
      sync2_ff <= `SYNC_RESET;
      sync3_ff <= `SYNC_RESET;
      filt_ff <= `SYNC_RESET;
    end else begin
      sync1_ff <= {BUS_RELEASE_ACK_N_I, READY_I, HOLD_N_I};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff <= (sync3_ff & ~flip) | (filt_ff & flip);
    end
  end

  assign hold_req = ~filt_ff[0];
  assign ready_lvl = filt_ff[1];
  assign granted = ~filt_ff[2];
  assign slave = arb_on_ff & PORT6_DIR_BIT7;
  // master starts from idle unless a hold must be granted first
  assign go_start = ((state_ff == S_IDLE) && pend_ff && !SINGLE_CHIP && !slave &&
                     !(arb_on_ff && hold_req)) || ((state_ff == S_GNT) && granted);

  // ----------------------------------------------------------------
  // request intake and arbitration enable latch
  // ----------------------------------------------------------------
  // the pins stay under controller control once enabled, even if
  // software later clears the enable bit
  always @(posedge MCLK) begin
    if (SRST) begin
      arb_on_ff <= 1'b0;
      BUS_RELEASE_ACK_N_OE <= 1'b0;
    end else begin
      if (ARBITRATION_ENABLE_BIT) begin
        arb_on_ff <= 1'b1;
      end
      // master drives the ack pin, slave listens on it
      BUS_RELEASE_ACK_N_OE <= arb_on_ff & !PORT6_DIR_BIT7;
    end
  end

  // ----------------------------------------------------------------
  // bus sequencer
  // ----------------------------------------------------------------
  always @(posedge MCLK) begin
    if (SRST) begin
      state_ff <= S_IDLE;
      pend_ff <= 1'b0;
      wr_ff <= 1'b0;
      addr_ff <= 24'h000000;
      wdata_ff <= 16'h0000;
      win_ff <= `WIN_DEFAULT;
      cfg_ff <= 13'h0000;
      wcnt_ff <= 4'h0;
      ACK <= 1'b0;
      RDATA <= 16'h0000;
      BUSY <= 1'b0;
      ADDRESS_PORT <= 16'h0000;
      SEGMENT_PORT <= 8'h00;
      DATA_MUX_PORT_O <= 16'h0000;
      DATA_MUX_PORT_OE <= 2'h0;
      ALE <= 1'b0;
      RD_N <= 1'b1;
      WR_N <= 1'b1;
      CHIP_SELECT_N <= `CS_IDLE;
      BUS_OE <= 1'b1;
      BUS_WANT_REQUEST_N <= 1'b1;
      BUS_RELEASE_ACK_N_O <= 1'b1;
    end else begin
      ACK <= 1'b0;
      // accept one request at a time; BUSY refuses the rest
      if (REQ && !BUSY) begin
        pend_ff <= 1'b1;
        BUSY <= 1'b1;
        wr_ff <= REQ_WR;
        addr_ff <= REQ_ADDR;
        wdata_ff <= REQ_WDATA;
        win_ff <= win_sel;
        cfg_ff <= cfg_sel;
      end
      // address phase, common to master start and slave grant
      if (go_start) begin
        pend_ff <= 1'b0;
        BUS_OE <= 1'b1;
        ALE <= 1'b1;
        SEGMENT_PORT <= addr_ff[23:16] & seg_mask(ADDR_SPACE);
        if (cfg_ff[`CFG_MUX]) begin
          ADDRESS_PORT <= 16'h0000;
          DATA_MUX_PORT_O <= addr_ff[15:0];
          DATA_MUX_PORT_OE <= 2'h3;
        end else begin
          ADDRESS_PORT <= addr_ff[15:0];
          DATA_MUX_PORT_OE <= 2'h0;
        end
        if (CHIP_SELECT_TIMING_BIT) begin
          CHIP_SELECT_N <= cs_vec(win_ff, cfg_ff[`CFG_CSEN]);
        end
        state_ff <= S_ADDR;
      end
      case (state_ff)
        S_IDLE: begin
          if (pend_ff && SINGLE_CHIP) begin
            // no pins move in single-chip mode
            pend_ff <= 1'b0;
            BUSY <= 1'b0;
            ACK <= 1'b1;
            RDATA <= 16'h0000;
          end else if (arb_on_ff && !slave && hold_req) begin
            // release the bus to the other master
            BUS_OE <= 1'b0;
            DATA_MUX_PORT_OE <= 2'h0;
            CHIP_SELECT_N <= `CS_IDLE;
            BUS_RELEASE_ACK_N_O <= 1'b0;
            state_ff <= S_HOLD;
          end else if (pend_ff && slave) begin
            BUS_WANT_REQUEST_N <= 1'b0;
            state_ff <= S_GNT;
          end else if (slave) begin
            BUS_OE <= 1'b0;
          end
        end
        S_ADDR: begin
          if (!CHIP_SELECT_TIMING_BIT) begin
            // one clock here is half a CPU clock
            CHIP_SELECT_N <= cs_vec(win_ff, cfg_ff[`CFG_CSEN]);
          end
          if (cfg_ff[`CFG_ALEX]) begin
            state_ff <= S_ALEX;
          end else begin
            ALE <= 1'b0;
            state_ff <= S_DLY;
          end
        end
        S_ALEX: begin
          ALE <= 1'b0;
          state_ff <= S_DLY;
        end
        S_DLY: begin
          // data phase; 8-bit buses use the low byte only
          if (wr_ff) begin
            DATA_MUX_PORT_O <= cfg_ff[`CFG_WIDE] ? wdata_ff : {8'h00, wdata_ff[7:0]};
            DATA_MUX_PORT_OE <= cfg_ff[`CFG_WIDE] ? 2'h3 : 2'h1;
          end else begin
            DATA_MUX_PORT_OE <= 2'h0;
          end
          wcnt_ff <= cfg_ff[`CFG_WAIT_MSB:`CFG_WAIT_LSB];
          // delayed strobe waits one extra clock in this state
          if (!cfg_ff[`CFG_RWDLY] || (!RD_N || !WR_N) || wcnt_ff == 4'hF) begin
            RD_N <= wr_ff;
            WR_N <= !wr_ff;
            state_ff <= S_STRB;
          end else begin
            wcnt_ff <= 4'hF;
          end
        end
        S_STRB: begin
          if (wcnt_ff != 4'h0) begin
            wcnt_ff <= wcnt_ff - 4'h1;
          end else if (cfg_ff[`CFG_RDYEN] && (ready_lvl != cfg_ff[`CFG_RDY_LVL])) begin
            // hold the strobe until ready shows its active level
            state_ff <= S_STRB;
          end else begin
            RD_N <= 1'b1;
            WR_N <= 1'b1;
            CHIP_SELECT_N <= `CS_IDLE;
            DATA_MUX_PORT_OE <= 2'h0;
            RDATA <= cfg_ff[`CFG_WIDE] ? DATA_MUX_PORT_I : {8'h00, DATA_MUX_PORT_I[7:0]};
            ACK <= 1'b1;
            BUSY <= 1'b0;
            state_ff <= cfg_ff[`CFG_TRI] ? S_TRI : S_IDLE;
            if (slave) begin
              BUS_WANT_REQUEST_N <= 1'b1;
            end
          end
        end
        S_TRI: begin
          state_ff <= S_IDLE;
        end
        S_HOLD: begin
          // ask for the bus back while work is waiting
          BUS_WANT_REQUEST_N <= !pend_ff;
          if (!hold_req) begin
            BUS_OE <= 1'b1;
            BUS_RELEASE_ACK_N_O <= 1'b1;
            BUS_WANT_REQUEST_N <= 1'b1;
            state_ff <= S_IDLE;
          end
        end
        S_GNT: begin
          // waiting; go_start above fires once granted
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end
endmodule // external_bus_unit

// ### tb/ebu_asserts.sv
module ebu_checker (
  input logic MCLK, // clock
  input logic SRST, // reset
  input logic REQ, // request
  input logic BUSY, // busy
  input logic ACK, // done
  input logic [15:0] RDATA, // read data
  input logic SINGLE_CHIP, // no bus
  input logic [1:0] ADDR_SPACE, // space code
  input logic CHIP_SELECT_TIMING_BIT, // cs timing
  input logic ARBITRATION_ENABLE_BIT, // arb on
  input logic PORT6_DIR_BIT7, // slave
  input logic HOLD_N_I, // hold pin
  input logic [7:0] SEGMENT_PORT, // segment
  input logic [1:0] DATA_MUX_PORT_OE, // lanes
  input logic ALE, // strobe
  input logic RD_N, // read
  input logic [4:0] CHIP_SELECT_N, // selects
  input logic BUS_OE, // drive
  input logic BUS_WANT_REQUEST_N, // request pin
  input logic BUS_RELEASE_ACK_N_O, // ack out
  input logic BUS_RELEASE_ACK_N_OE // ack enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic arb_seen_ff = 1'b0; // arbitration switched on since reset
  wire [7:0] seg_allow = (ADDR_SPACE == 2'h0) ? 8'hFF : (ADDR_SPACE == 2'h1) ? 8'h0F :
    (ADDR_SPACE == 2'h2) ? 8'h03 : 8'h00; // segment lines the space may drive
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (SRST);
  // sticky, so a later drop of the enable bit cannot hide a takeover
  always @(posedge MCLK) begin
    if (SRST) arb_seen_ff <= 1'b0;
    else if (ARBITRATION_ENABLE_BIT) arb_seen_ff <= 1'b1;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_single;
    REQ && !BUSY && SINGLE_CHIP |=> BUSY ##1 (ACK && RDATA == 16'h0000);
  endproperty
  a_single: assert property (p_single) else $error("single chip access wrong");
  property p_read_lanes;
    !RD_N |-> DATA_MUX_PORT_OE == 2'h0;
  endproperty
  a_read_lanes: assert property (p_read_lanes) else $error("data driven in read");
  property p_seg;
    ALE |-> (SEGMENT_PORT & ~seg_allow) == 8'h00;
  endproperty
  a_seg: assert property (p_seg) else $error("segment line beyond space");
  property p_one_cs;
    $onehot0(~CHIP_SELECT_N);
  endproperty
  a_one_cs: assert property (p_one_cs) else $error("two chip selects active");
  property p_cs_late;
    !CHIP_SELECT_TIMING_BIT && CHIP_SELECT_N != 5'h1F && $past(CHIP_SELECT_N) == 5'h1F
      |-> $past(ALE) && !$past(ALE, 2);
  endproperty
  a_cs_late: assert property (p_cs_late) else $error("chip select not one cycle late");
  property p_cs_early;
    CHIP_SELECT_TIMING_BIT && CHIP_SELECT_N != 5'h1F && $past(CHIP_SELECT_N) == 5'h1F
      |-> $rose(ALE);
  endproperty
  a_cs_early: assert property (p_cs_early) else $error("chip select not with ALE");
  property p_slave;
    PORT6_DIR_BIT7 && $past(PORT6_DIR_BIT7) |-> !BUS_RELEASE_ACK_N_OE;
  endproperty
  a_slave: assert property (p_slave) else $error("ack pin driven in slave");
  property p_arb_off;
    !arb_seen_ff |-> BUS_WANT_REQUEST_N && BUS_RELEASE_ACK_N_O;
  endproperty
  a_arb_off: assert property (p_arb_off) else $error("arbitration pins moved");
  property p_hold;
    (!HOLD_N_I && !BUSY && ARBITRATION_ENABLE_BIT && !PORT6_DIR_BIT7) [*8]
      |-> !BUS_OE && DATA_MUX_PORT_OE == 2'h0;
  endproperty
  a_hold: assert property (p_hold) else $error("bus not floated in hold");
endmodule // ebu_checker

bind external_bus_unit ebu_checker i_chk (.MCLK, .SRST, .REQ, .BUSY, .ACK, .RDATA, .SINGLE_CHIP,
  .ADDR_SPACE, .CHIP_SELECT_TIMING_BIT, .ARBITRATION_ENABLE_BIT, .PORT6_DIR_BIT7, .HOLD_N_I,
  .SEGMENT_PORT, .DATA_MUX_PORT_OE, .ALE, .RD_N, .CHIP_SELECT_N, .BUS_OE,
  .BUS_WANT_REQUEST_N, .BUS_RELEASE_ACK_N_O, .BUS_RELEASE_ACK_N_OE);

// ### tb/bus_memory_model.sv
module bus_memory_model (
  input logic clk, // bus clock
  input logic [15:0] addr_lines, // demux address
  input logic [15:0] dout, // data from controller
  input logic [1:0] doe, // byte lane drive
  input logic ale, // address strobe
  input logic rd_n, // read strobe
  input logic wr_n, // write strobe
  input logic rdy_pol, // ready active level
  input logic [7:0] rdy_dly, // strobe cycles before ready
  output logic [15:0] din, // data to controller
  output logic ready // ready pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16]; // word store, index from address bits 5..2
  logic [15:0] lat_ff = 16'h0000; // latched address
  logic [15:0] last_ff = 16'h0000; // last word driven
  logic [7:0] cnt_ff = 8'h00; // strobe age
  wire [3:0] idx = lat_ff[5:2];
  wire strobe = !rd_n || !wr_n;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
  // a released bus shows the inverse of the last word, so stale data never passes
  assign din = rd_n ? ~last_ff : mem[idx];
  // ready only at the programmed level once the strobe has aged enough
  assign ready = (strobe && cnt_ff >= rdy_dly) ? rdy_pol : ~rdy_pol;
  // mux modes put the address on the data port, demux on the address port
  always @(posedge clk) begin
    if (ale) lat_ff <= (addr_lines != 16'h0000) ? addr_lines : dout;
    cnt_ff <= strobe ? cnt_ff + 8'h01 : 8'h00;
    if (!rd_n) last_ff <= mem[idx];
    if (!wr_n && doe[0]) mem[idx][7:0] <= dout[7:0];
    if (!wr_n && doe[1]) mem[idx][15:8] <= dout[15:8];
  end
endmodule // bus_memory_model

// ### tb/external_bus_unit_bench.sv
module external_bus_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic w; logic [23:0] a; logic [15:0] d; logic [4:0] cs; logic [1:0] al;}
    row_t;
  logic MCLK = 1'b0, SRST = 1'b1, REQ = 1'b0, REQ_WR = 1'b0, SINGLE_CHIP = 1'b0, rdy_pol = 1'b1;
  logic CHIP_SELECT_TIMING_BIT = 1'b0, ARBITRATION_ENABLE_BIT = 1'b0, PORT6_DIR_BIT7 = 1'b0;
  logic HOLD_N_I = 1'b1, BUS_RELEASE_ACK_N_I = 1'b1, got;
  logic [1:0] ADDR_SPACE = 2'h0, ale_cnt;
  logic [23:0] REQ_ADDR = 24'h000000;
  logic [15:0] REQ_WDATA = 16'h0000, adr_seen, dat_seen;
  logic [12:0] DEFAULT_BUS_CONFIG_REG = 13'h0802, WINDOW1_BUS_CONFIG = 13'h1803;
  logic [12:0] WINDOW2_BUS_CONFIG = 13'h1800, WINDOW3_BUS_CONFIG = 13'h19CA;
  logic [12:0] WINDOW4_BUS_CONFIG = 13'h1E02;
  logic [15:0] WINDOW_SELECT_REG1 = 16'h0002, WINDOW_SELECT_REG2 = 16'h0010;
  logic [15:0] WINDOW_SELECT_REG3 = 16'h0101, WINDOW_SELECT_REG4 = 16'h0100;
  logic [7:0] rdy_dly = 8'h00, seg_seen;
  logic [4:0] cs_seen;
  wire ACK, BUSY, ALE, RD_N, WR_N, BUS_OE, BUS_WANT_REQUEST_N, READY_I;
  wire BUS_RELEASE_ACK_N_O, BUS_RELEASE_ACK_N_OE;
  wire [15:0] RDATA, ADDRESS_PORT, DATA_MUX_PORT_O, DATA_MUX_PORT_I;
  wire [7:0] SEGMENT_PORT;
  wire [1:0] DATA_MUX_PORT_OE;
  wire [4:0] CHIP_SELECT_N;
  int fails = 0, cmp_count = 0;
  // window 2 nests in window 1, window 4 in window 3; upper addresses fall to default
  row_t rows [10] = '{
    '{1'b1, 24'h100020, 16'hA5C3, 5'h01, 2'h1}, '{1'b0, 24'h100020, 16'hA5C3, 5'h01, 2'h1},
    '{1'b1, 24'h001024, 16'h1234, 5'h04, 2'h1}, '{1'b0, 24'h001024, 16'h0034, 5'h04, 2'h1},
    '{1'b1, 24'h00202C, 16'hBEEF, 5'h02, 2'h1}, '{1'b0, 24'h00202C, 16'hBEEF, 5'h02, 2'h1},
    '{1'b1, 24'h010030, 16'h5A5A, 5'h10, 2'h1}, '{1'b0, 24'h010030, 16'h5A5A, 5'h10, 2'h1},
    '{1'b1, 24'h011034, 16'hC0DE, 5'h08, 2'h2}, '{1'b0, 24'h011034, 16'hC0DE, 5'h08, 2'h2}};
  logic [7:0] segx [4] = '{8'hF3, 8'h03, 8'h03, 8'h00}; // F3 under each space mask
  external_bus_unit i_dut (.MCLK, .SRST, .REQ, .REQ_WR, .REQ_ADDR, .REQ_WDATA, .ACK, .RDATA,
    .BUSY, .SINGLE_CHIP, .ADDR_SPACE, .CHIP_SELECT_TIMING_BIT, .ARBITRATION_ENABLE_BIT,
    .PORT6_DIR_BIT7, .DEFAULT_BUS_CONFIG_REG, .WINDOW1_BUS_CONFIG, .WINDOW2_BUS_CONFIG,
    .WINDOW3_BUS_CONFIG, .WINDOW4_BUS_CONFIG, .WINDOW_SELECT_REG1, .WINDOW_SELECT_REG2,
    .WINDOW_SELECT_REG3, .WINDOW_SELECT_REG4, .ADDRESS_PORT, .SEGMENT_PORT, .DATA_MUX_PORT_O,
    .DATA_MUX_PORT_OE, .DATA_MUX_PORT_I, .ALE, .RD_N, .WR_N, .CHIP_SELECT_N, .BUS_OE, .READY_I,
    .HOLD_N_I, .BUS_WANT_REQUEST_N, .BUS_RELEASE_ACK_N_I, .BUS_RELEASE_ACK_N_O,
    .BUS_RELEASE_ACK_N_OE);
  bus_memory_model i_mem (.clk(MCLK), .addr_lines(ADDRESS_PORT), .dout(DATA_MUX_PORT_O),
    .doe(DATA_MUX_PORT_OE), .ale(ALE), .rd_n(RD_N), .wr_n(WR_N), .rdy_pol(rdy_pol),
    .rdy_dly(rdy_dly), .din(DATA_MUX_PORT_I), .ready(READY_I));
  initial forever #5 MCLK = ~MCLK;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // arbitration state goes low with reset so the sticky enable restarts cleanly
  task automatic rst();
    @(posedge MCLK);
    SRST <= 1'b1;
    ARBITRATION_ENABLE_BIT <= 1'b0;
    PORT6_DIR_BIT7 <= 1'b0;
    repeat (4) @(posedge MCLK);
    SRST <= 1'b0;
  endtask
  // samples at falling edges, so every registered output has settled
  task automatic wait_ack(input int lim, input logic must);
    got = 1'b0;
    cs_seen = 5'h00;
    ale_cnt = 2'h0;
    for (int n = 0; n < lim && !got; n++) begin
      @(negedge MCLK);
      cs_seen = cs_seen | ~CHIP_SELECT_N;
      if (ALE === 1'b1) begin
        ale_cnt = ale_cnt + 2'h1;
        seg_seen = SEGMENT_PORT;
        adr_seen = ADDRESS_PORT;
        dat_seen = DATA_MUX_PORT_O;
      end
      got = (ACK === 1'b1);
    end
    if (must && !got) begin
      fails++;
      end_sim();
    end
  endtask
  task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d, input int lim,
    input logic must);
    @(posedge MCLK);
    REQ <= 1'b1;
    REQ_WR <= w;
    REQ_ADDR <= a;
    REQ_WDATA <= d;
    @(posedge MCLK);
    REQ <= 1'b0;
    wait_ack(lim, must);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst();
    for (int i = 0; i < 10; i++) begin
      acc(rows[i].w, rows[i].a, rows[i].d, 60, 1'b1);
      chk(cs_seen, rows[i].cs);
      chk(ale_cnt, rows[i].al);
      if (!rows[i].w) chk(RDATA, rows[i].d);
    end
    // each default bus mode once, mode k under space restriction k
    for (int k = 0; k < 4; k++) begin
      @(posedge MCLK);
      ADDR_SPACE <= k[1:0];
      DEFAULT_BUS_CONFIG_REG <= {11'h200, k[1:0]};
      acc(1'b1, 24'hF30040, 16'h9D6B, 60, 1'b1);
      chk(seg_seen, segx[k]);
      chk(k[0] ? dat_seen : adr_seen, 16'h0040);
      acc(1'b0, 24'hF30040, 16'h0000, 60, 1'b1);
      chk(RDATA, k[1] ? 16'h9D6B : 16'h006B);
    end
    // slow device: no end before ready, then the other polarity
    @(posedge MCLK);
    rdy_dly <= 8'h3C;
    acc(1'b0, 24'h010030, 16'h0000, 40, 1'b0);
    chk(got, 1'b0);
    wait_ack(100, 1'b1);
    chk(RDATA, 16'h5A5A);
    @(posedge MCLK);
    WINDOW4_BUS_CONFIG <= 13'h1A02;
    rdy_pol <= 1'b0;
    rdy_dly <= 8'h0A;
    acc(1'b0, 24'h010030, 16'h0000, 10, 1'b0);
    chk(got, 1'b0);
    wait_ack(40, 1'b1);
    chk(RDATA, 16'h5A5A);
    // another master holds the bus while a request waits
    @(posedge MCLK);
    ARBITRATION_ENABLE_BIT <= 1'b1;
    HOLD_N_I <= 1'b0;
    repeat (10) @(negedge MCLK);
    chk({BUS_OE, BUS_RELEASE_ACK_N_O, BUS_RELEASE_ACK_N_OE}, 3'h1);
    acc(1'b0, 24'h100020, 16'h0000, 12, 1'b0);
    chk({got, BUS_WANT_REQUEST_N}, 2'h0);
    @(posedge MCLK);
    HOLD_N_I <= 1'b1;
    wait_ack(40, 1'b1);
    chk({BUS_OE, RDATA}, {1'b1, 16'hA5C3});
    // slave mode: the ack pin becomes the grant input
    @(posedge MCLK);
    PORT6_DIR_BIT7 <= 1'b1;
    repeat (4) @(negedge MCLK);
    chk({BUS_RELEASE_ACK_N_OE, BUS_OE}, 2'h0);
    acc(1'b0, 24'h100020, 16'h0000, 12, 1'b0);
    chk({got, BUS_WANT_REQUEST_N}, 2'h0);
    @(posedge MCLK);
    BUS_RELEASE_ACK_N_I <= 1'b0;
    wait_ack(40, 1'b1);
    chk(RDATA, 16'hA5C3);
    @(posedge MCLK);
    BUS_RELEASE_ACK_N_I <= 1'b1;
    rst();
    @(negedge MCLK);
    chk({ACK, BUSY, BUS_OE, BUS_RELEASE_ACK_N_OE, CHIP_SELECT_N}, 9'h05F);
    @(posedge MCLK);
    CHIP_SELECT_TIMING_BIT <= 1'b1;
    acc(1'b0, 24'h001024, 16'h0000, 60, 1'b1);
    chk({cs_seen, RDATA}, {5'h04, 16'h0034});
    @(posedge MCLK);
    SINGLE_CHIP <= 1'b1;
    acc(1'b0, 24'h100020, 16'h0000, 10, 1'b1);
    chk({ale_cnt, cs_seen, RDATA}, 23'h000000);
    end_sim();
  end
endmodule // external_bus_unit_bench
